// ### logic/codec_interrupt_controller.sv
`timescale 1ns/10ps
// Function
// - Many event sources accepted; any subset may be enabled to raise interrupt.
// - Each source has a status bit readable at any time.
// - Interrupt is signalled to the host on a GPIO pin output.
// - Each source individually maskable by a mask register bit.
// - Status keeps capturing while masked; masked bits never drive interrupt.
// - Interrupt equals OR of unmasked status bits.
// - Status bits latch until host writes one to that bit.
// - Interrupt deasserts only after all unmasked status bits clear.
// - Still-active source re-sets its bit after clear; interrupt stays.
// - Synth2, synth3, freq loop lock and overheat sources optionally debounced, enabled per bit.
// - Debounce clock runs from timeout clock whenever any debounce enabled.
// - Debounce clock rate set by programmable divider field.
// - Interrupt output active high after reset; polarity bit inverts it.
// - First status register: pin6 event bit 5, pin5 event bit 4.
// - Second status register bits 15 down to 5 hold listed events.
// - All status bits read zero after reset.
// - Second status: synth3 lock bit 3, synth2 bit 2, overheat bit 0.
// - Mask 1 means masked; mic masks reset 0, others reset 1.
// - Debounce enables for synth2, synth3, freq loop lock and overheat sources reset to one.
module codec_interrupt_controller #(
   parameter int DIV_W = codec_irq_pkg::DIV_W
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_clk_en,
   input wire logic i_timeout_tick,
   input wire codec_irq_pkg::irq_src_s i_src,
   input wire codec_irq_pkg::reg_req_s i_req,
   output logic [15:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_irq_pin
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [15:0] status_gpio_q;
   logic [15:0] status_src_q;
   logic [15:0] mask_gpio_q;
   logic [15:0] mask_src_q;
   logic [15:0] debounce_en_q;
   logic [15:0] mic_pol_q;
   logic irq_pol_q;
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic db_tick;
   logic db_run;
   logic div_hit;
   logic [15:0] src_cond;
   logic [15:0] src_filt;
   logic [15:0] rd_data_q;
   logic rd_valid_q;
   logic irq_q;
   logic irq_d;
   logic [15:0] rd_mux;

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   logic wr_status_gpio;
   logic wr_status_src;
   logic wr_mask_gpio;
   logic wr_mask_src;
   logic wr_control;
   logic wr_debounce;
   logic wr_mic_pol;
   logic wr_div;

   // Address compare per register
   assign wr_status_gpio = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_STATUS_GPIO);
   assign wr_status_src = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_STATUS_SOURCES);
   assign wr_mask_gpio = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_MASK_GPIO);
   assign wr_mask_src = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_MASK_SOURCES);
   assign wr_control = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_IRQ_CONTROL);
   assign wr_debounce = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_DEBOUNCE);
   assign wr_mic_pol = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_MIC_POLARITY);
   assign wr_div = i_req.wr && (i_req.addr == codec_irq_pkg::ADDR_DEBOUNCE_DIV);

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------

   // Mask registers, 1 = masked
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mask_gpio_q <= codec_irq_pkg::MASK_GPIO_RESET;
         mask_src_q <= codec_irq_pkg::MASK_SOURCES_RESET;
      end
      else if (i_clk_en)
      begin
         if (wr_mask_gpio)
         begin
            mask_gpio_q <= i_req.wdata & codec_irq_pkg::GPIO_VALID;
         end
         if (wr_mask_src)
         begin
            mask_src_q <= i_req.wdata & codec_irq_pkg::SOURCES_VALID;
         end
      end
   end

   // Debounce enables, one per filtered source
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         debounce_en_q <= codec_irq_pkg::DEBOUNCE_RESET;
      end
      else if (i_clk_en)
      begin
         if (wr_debounce)
         begin
            debounce_en_q <= i_req.wdata & codec_irq_pkg::DEBOUNCE_VALID;
         end
      end
   end

   // Debounce clock divider field
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         div_q <= DIV_W'(codec_irq_pkg::DIV_RESET);
      end
      else if (i_clk_en)
      begin
         if (wr_div)
         begin
            div_q <= i_req.wdata[DIV_W-1:0];
         end
      end
   end

   // Output polarity
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         irq_pol_q <= codec_irq_pkg::IRQ_POL_RESET;
      end
      else if (i_clk_en)
      begin
         if (wr_control)
         begin
            irq_pol_q <= i_req.wdata[codec_irq_pkg::BIT_IRQ_POL];
         end
      end
   end

   // Mic source polarity
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mic_pol_q <= codec_irq_pkg::MIC_POL_RESET;
      end
      else if (i_clk_en)
      begin
         if (wr_mic_pol)
         begin
            mic_pol_q <= i_req.wdata & codec_irq_pkg::MIC_POL_VALID;
         end
      end
   end

   // ------------------------------------------------------------
   // Debounce clock
   // ------------------------------------------------------------

   // Runs only while some debounce enable is set
   assign db_run = |debounce_en_q;

   // Divider terminal count reached
   assign div_hit = (div_cnt_q >= div_q);

   // Divide the timeout clock ticks by div_q + 1
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         div_cnt_q <= '0;
      end
      else if (i_clk_en)
      begin
         if (!db_run)
         begin
            div_cnt_q <= '0;
         end
         else if (i_timeout_tick)
         begin
            if (div_hit)
            begin
               div_cnt_q <= '0;
            end
            else
            begin
               div_cnt_q <= div_cnt_q + DIV_W'(1);
            end
         end
      end
   end

   assign db_tick = db_run && i_timeout_tick && div_hit;

   // ------------------------------------------------------------
   // Source conditioning
   // ------------------------------------------------------------

   // Mic sources may be taken active low
   assign src_cond = (i_src.sources ^ mic_pol_q) & codec_irq_pkg::SOURCES_VALID;

   // Per-bit debounce: level must hold over two debounce ticks
   for (genvar b = 0; b < 16; b++)
   begin : g_filt
      if (codec_irq_pkg::DEBOUNCE_VALID[b])
      begin : g_db
         logic [1:0] samp_q;
         always_ff @(posedge i_core_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               samp_q <= 2'h0;
            end
            else if (i_clk_en && !debounce_en_q[b])
            begin
               samp_q <= 2'h0;
            end
            else if (i_clk_en && db_tick)
            begin
               samp_q <= {samp_q[0], src_cond[b]};
            end
         end
         // Debounced only when this source's enable is set
         assign src_filt[b] = debounce_en_q[b] ? (&samp_q) : src_cond[b];
      end
      else
      begin : g_raw
         assign src_filt[b] = src_cond[b];
      end
   end

   // ------------------------------------------------------------
   // Status latches
   // ------------------------------------------------------------

   // Set each active cycle, write one clears, set wins
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         status_gpio_q <= codec_irq_pkg::STATUS_RESET;
      end
      else if (i_clk_en)
      begin
         status_gpio_q <= ((status_gpio_q & ~({16{wr_status_gpio}} & i_req.wdata))
                           | i_src.gpio) & codec_irq_pkg::GPIO_VALID;
      end
   end

   // Second status register, same behaviour
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         status_src_q <= codec_irq_pkg::STATUS_RESET;
      end
      else if (i_clk_en)
      begin
         status_src_q <= ((status_src_q & ~({16{wr_status_src}} & i_req.wdata))
                          | src_filt) & codec_irq_pkg::SOURCES_VALID;
      end
   end

   // ------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------

   // OR of unmasked status bits
   assign irq_d = |(status_gpio_q & ~mask_gpio_q) | |(status_src_q & ~mask_src_q);

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         irq_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         irq_q <= irq_d;
      end
   end

   // Pin level with polarity applied
   assign o_irq_pin = irq_q ^ irq_pol_q;

   // ------------------------------------------------------------
   // Readback
   // ------------------------------------------------------------

   // Select register by address; unmapped reads zero
   always_comb
   begin
      case (i_req.addr)
         codec_irq_pkg::ADDR_STATUS_GPIO: rd_mux = status_gpio_q;
         codec_irq_pkg::ADDR_STATUS_SOURCES: rd_mux = status_src_q;
         codec_irq_pkg::ADDR_MASK_GPIO: rd_mux = mask_gpio_q;
         codec_irq_pkg::ADDR_MASK_SOURCES: rd_mux = mask_src_q;
         codec_irq_pkg::ADDR_IRQ_CONTROL: rd_mux = {15'h0000, irq_pol_q};
         codec_irq_pkg::ADDR_DEBOUNCE: rd_mux = debounce_en_q;
         codec_irq_pkg::ADDR_MIC_POLARITY: rd_mux = mic_pol_q;
         codec_irq_pkg::ADDR_DEBOUNCE_DIV: rd_mux = {{(16-DIV_W){1'b0}}, div_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   // Registered read data, one cycle after request
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         rd_valid_q <= i_req.rd;
         if (i_req.rd)
         begin
            rd_data_q <= rd_mux;
         end
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_rd_valid = rd_valid_q;

endmodule // codec_interrupt_controller

// ### logic/codec_irq_pkg.sv
package codec_irq_pkg;

   // ------------------------------------------------------------
   // Register access widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [9:0] ADDR_STATUS_GPIO = 10'h230;
   localparam logic [9:0] ADDR_STATUS_SOURCES = 10'h231;
   localparam logic [9:0] ADDR_MASK_GPIO = 10'h238;
   localparam logic [9:0] ADDR_MASK_SOURCES = 10'h239;
   localparam logic [9:0] ADDR_IRQ_CONTROL = 10'h240;
   localparam logic [9:0] ADDR_DEBOUNCE = 10'h248;
   localparam logic [9:0] ADDR_MIC_POLARITY = 10'h24A;
   localparam logic [9:0] ADDR_DEBOUNCE_DIV = 10'h24C;

   // ------------------------------------------------------------
   // Field positions, first status register
   // ------------------------------------------------------------
   localparam int BIT_PIN6 = 5;
   localparam int BIT_PIN5 = 4;

   // ------------------------------------------------------------
   // Field positions, second status register
   // ------------------------------------------------------------
   localparam int BIT_MIC_SHORT = 15;
   localparam int BIT_MIC_DETECT = 14;
   localparam int BIT_FIFO_ERROR = 13;
   localparam int BIT_LEVEL_LOCK = 12;
   localparam int BIT_LEVEL_THRESHOLD = 11;
   localparam int BIT_LEVEL_SATURATION = 10;
   localparam int BIT_PEAK_OVERLOAD = 9;
   localparam int BIT_NOISE_GATE = 8;
   localparam int BIT_SEQUENCER_DONE = 7;
   localparam int BIT_RANGE_ACTIVITY = 6;
   localparam int BIT_FREQ_LOOP_LOCK = 5;
   localparam int BIT_SYNTH3_LOCK = 3;
   localparam int BIT_SYNTH2_LOCK = 2;
   localparam int BIT_OVERHEAT = 0;
   localparam int BIT_IRQ_POL = 0;

   // ------------------------------------------------------------
   // Implemented bits and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] GPIO_VALID = 16'h0030;
   localparam logic [15:0] SOURCES_VALID = 16'hFFED;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] MASK_GPIO_RESET = 16'h0030;
   localparam logic [15:0] MASK_SOURCES_RESET = 16'h3FED;
   localparam logic [15:0] DEBOUNCE_VALID = 16'h002D;
   localparam logic [15:0] DEBOUNCE_RESET = 16'h002D;
   localparam logic [15:0] MIC_POL_VALID = 16'hC000;
   localparam logic [15:0] MIC_POL_RESET = 16'h0000;
   localparam logic IRQ_POL_RESET = 1'b0;
   localparam int DIV_W = 4;
   localparam logic [3:0] DIV_RESET = 4'h0;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] gpio;
      logic [DATA_W-1:0] sources;
   } irq_src_s;

endpackage

// ### test/codec_interrupt_controller_asserts.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module codec_irq_checker #(
   parameter int DIV_W = 4
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_clk_en,
   input wire logic i_timeout_tick,
   input wire codec_irq_pkg::irq_src_s i_src,
   input wire codec_irq_pkg::reg_req_s i_req,
   input wire logic [15:0] o_rd_data,
   input wire logic o_rd_valid,
   input wire logic o_irq_pin
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   logic rd_en;
   logic wr_en;
   logic src13_q;
   logic is_src;
   // Qualified strobes and target decode
   assign rd_en = i_req.rd && i_clk_en;
   assign wr_en = i_req.wr && i_clk_en;
   assign is_src = i_req.addr == codec_irq_pkg::ADDR_STATUS_SOURCES;
   // Source level seen at the previous edge, zero if the enable was low there
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         src13_q <= 1'b0;
      else
         src13_q <= i_src.sources[13] & i_clk_en;
   end
   rd_valid_a: assert property (rd_en |=> o_rd_valid)
      else $error("read gave no valid pulse");
   valid_pulse_a: assert property (i_clk_en && !i_req.rd |=> !o_rd_valid)
      else $error("valid pulse without read");
   data_hold_a: assert property (!rd_en |=> $stable(o_rd_data))
      else $error("read data moved without read");
   unmapped_zero_a: assert property (rd_en && !(i_req.addr inside {10'h230, 10'h231,
      10'h238, 10'h239, 10'h240, 10'h248, 10'h24A, 10'h24C}) |=> o_rd_data == 16'h0000)
      else $error("unmapped read not zero");
   gpio_unused_a: assert property (rd_en && i_req.addr == 10'h230
      |=> (o_rd_data & 16'hFFCF) == 16'h0000) else $error("unused pin status bits set");
   src_unused_a: assert property (rd_en && is_src
      |=> (o_rd_data & 16'h0012) == 16'h0000) else $error("unused source status bits set");
   irq_reset_a: assert property ($rose(i_resetn) |-> !o_irq_pin)
      else $error("pin active after reset");
   set_seen_a: assert property (rd_en && is_src && src13_q |=> o_rd_data[13])
      else $error("active source not latched");
   clear_one_a: assert property (wr_en && is_src && i_req.wdata[13] && !i_src.sources[13]
      ##1 rd_en && is_src |=> !o_rd_data[13]) else $error("write of one did not clear");
endmodule // codec_irq_checker

bind codec_interrupt_controller codec_irq_checker #(.DIV_W(DIV_W)) codec_irq_checker_inst (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
   .i_timeout_tick(i_timeout_tick), .i_src(i_src), .i_req(i_req),
   .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_irq_pin(o_irq_pin));

// ### test/host_bus_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module host_bus_model (
   input wire logic i_core_clk,
   input wire logic [15:0] i_rd_data,
   input wire logic i_rd_valid,
   output codec_irq_pkg::reg_req_s o_req
);
   // Idle bus at start
   initial o_req = '0;
   // Present one request
   task automatic put(input logic w, input logic r, input logic [9:0] a, input logic [15:0] v);
      o_req = {w, r, a, v};
   endtask
   // Release; stale address and data are inverted
   task automatic idle();
      o_req = {1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] v);
      @(negedge i_core_clk);
      put(1'b1, 1'b0, a, v);
      @(negedge i_core_clk);
      idle();
   endtask
   task automatic rd(input logic [9:0] a, output logic [15:0] q);
      @(negedge i_core_clk);
      put(1'b0, 1'b1, a, 16'h0000);
      @(negedge i_core_clk);
      q = i_rd_valid ? i_rd_data : 16'hxxxx;
      idle();
   endtask
   // Clear by writing ones, then read back at once
   task automatic clr(input logic [9:0] a, input logic [15:0] v, output logic [15:0] q);
      @(negedge i_core_clk);
      put(1'b1, 1'b0, a, v);
      @(negedge i_core_clk);
      put(1'b0, 1'b1, a, 16'h0000);
      @(negedge i_core_clk);
      q = i_rd_valid ? i_rd_data : 16'hxxxx;
      idle();
   endtask
endmodule // host_bus_model

// ### test/codec_interrupt_controller_tb_top.sv
`timescale 1ns/10ps
module codec_interrupt_controller_tb_top;
   logic i_core_clk;
   logic i_resetn;
   logic i_clk_en;
   logic i_timeout_tick;
   codec_irq_pkg::irq_src_s i_src;
   codec_irq_pkg::reg_req_s req;
   logic [15:0] rd_data;
   logic rd_valid;
   logic irq_pin;
   logic [15:0] d;
   logic [15:0] e;
   logic [9:0] a;
   logic [9:0] rst_a [9] = '{10'h230, 10'h231, 10'h238, 10'h239, 10'h248, 10'h240, 10'h24A,
      10'h24C, 10'h3FF};
   logic [15:0] rst_v [9] = '{16'h0000, 16'h0000, 16'h0030, 16'h3FED, 16'h002D, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
   logic [31:0] vmask = {16'h0030, 16'hFFED};
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   // ------------------------------------------------------------
   // Clock, watchdog and instances
   // ------------------------------------------------------------
   initial
   begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         test_done();
      end
   end
   codec_interrupt_controller #(.DIV_W(4)) codec_interrupt_controller_inst (
      .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
      .i_timeout_tick(i_timeout_tick), .i_src(i_src), .i_req(req),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_irq_pin(irq_pin));
   host_bus_model host_bus_model_inst (
      .i_core_clk(i_core_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_req(req));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic rchk(input logic [9:0] ra, input logic [15:0] exp);
      logic [15:0] q;
      host_bus_model_inst.rd(ra, q);
      chk(q, exp);
   endtask
   task automatic pchk(input logic exp);
      chk({15'h0000, irq_pin}, {15'h0000, exp});
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic pulse(input int b);
      @(negedge i_core_clk);
      i_src = i_src | (32'h0000_0001 << b);
      @(negedge i_core_clk);
      i_src = i_src & ~(32'h0000_0001 << b);
   endtask
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(negedge i_core_clk);
         i_timeout_tick = 1'b1;
         @(negedge i_core_clk);
         i_timeout_tick = 1'b0;
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      i_resetn = 1'b0;
      i_clk_en = 1'b1;
      i_timeout_tick = 1'b0;
      i_src = '0;
      repeat (2) @(negedge i_core_clk);
      i_resetn = 1'b1;
      // Reset values and an unmapped place
      for (int i = 0; i < 9; i++)
         rchk(rst_a[i], rst_v[i]);
      pchk(1'b0);
      // Every status bit at its place, then cleared
      host_bus_model_inst.wr(10'h248, 16'h0000);
      for (int b = 0; b < 32; b++)
      begin
         if (vmask[b])
         begin
            a = (b < 16) ? 10'h231 : 10'h230;
            e = 16'h0001 << b[3:0];
            pulse(b);
            rchk(a, e);
            host_bus_model_inst.clr(a, e, d);
            chk(d, 16'h0000);
         end
      end
      // Masked source latches but stays off the pin
      pulse(13);
      wait_n(2);
      pchk(1'b0);
      rchk(10'h231, 16'h2000);
      host_bus_model_inst.wr(10'h239, 16'h0FED);
      wait_n(1);
      pchk(1'b1);
      pulse(12);
      host_bus_model_inst.wr(10'h231, 16'h0000);
      rchk(10'h231, 16'h3000);
      host_bus_model_inst.wr(10'h231, 16'h2000);
      wait_n(1);
      pchk(1'b1);
      host_bus_model_inst.wr(10'h231, 16'h1000);
      wait_n(1);
      pchk(1'b0);
      host_bus_model_inst.wr(10'h240, 16'h0001);
      wait_n(1);
      pchk(1'b1);
      host_bus_model_inst.wr(10'h240, 16'h0000);
      // Clear while the condition persists
      i_src.sources[13] = 1'b1;
      wait_n(1);
      host_bus_model_inst.clr(10'h231, 16'h2000, d);
      chk(d, 16'h2000);
      pchk(1'b1);
      i_src.sources[13] = 1'b0;
      host_bus_model_inst.clr(10'h231, 16'h2000, d);
      chk(d, 16'h0000);
      wait_n(1);
      pchk(1'b0);
      // Debounced overheat needs timeout ticks
      host_bus_model_inst.wr(10'h248, 16'h002D);
      host_bus_model_inst.wr(10'h24C, 16'h0003);
      i_src.sources[0] = 1'b1;
      wait_n(20);
      rchk(10'h231, 16'h0000);
      ticks(3);
      rchk(10'h231, 16'h0000);
      ticks(8);
      rchk(10'h231, 16'h0001);
      // Mic sources taken active low
      host_bus_model_inst.wr(10'h24A, 16'hC000);
      rchk(10'h24A, 16'hC000);
      rchk(10'h231, 16'hC001);
      pchk(1'b1);
      host_bus_model_inst.wr(10'h24A, 16'h0000);
      host_bus_model_inst.clr(10'h231, 16'hC000, d);
      chk(d, 16'h0001);
      pchk(1'b0);
      // Nothing latches while the clock enable is low
      i_clk_en = 1'b0;
      pulse(6);
      i_clk_en = 1'b1;
      rchk(10'h231, 16'h0001);
      test_done();
   end
endmodule // codec_interrupt_controller_tb_top
